// ==== cfg_bit_source.sv ====
`timescale 1ns/100ps
// far-side bit source: drives the slave clock and data, or follows the generated master clock
module cfg_bit_source (
  input wire logic link_clk,
  input wire logic mode_master,
  input wire logic pin_clock_out,
  input wire logic pin_clock_oe,
  output logic config_clock_in,
  output logic serial_data
);
  logic slave_run;
  initial begin
    slave_run = 1'b0;
    serial_data = 1'b0;
  end
  // released master pin shows the inverse of pin_clock_out, which is low whenever released, so it reads high
  always_comb begin
    if (!mode_master) begin
      config_clock_in = slave_run & link_clk;
    end else if (pin_clock_oe) begin
      config_clock_in = pin_clock_out;
    end else begin
      config_clock_in = ~pin_clock_out;
    end
  end
  // a few edges while the link enable is low clear the link-side counter
  task automatic prime_link();
    @(negedge link_clk);
    slave_run = 1'b1;
    repeat (4) @(negedge link_clk);
    slave_run = 1'b0;
  endtask
  // clock stands still low outside the frame; two lead edges carry the enable across
  task automatic send_slave(input logic [7:0] frame [$]);
    int i;
    int b;
    @(negedge link_clk);
    serial_data = 1'b1;
    slave_run = 1'b1;
    repeat (2) @(negedge link_clk);
    for (i = 0; i < frame.size(); i++) begin
      for (b = 7; b >= 0; b--) begin
        serial_data = frame[i][b];
        @(negedge link_clk);
      end
    end
    serial_data = ~serial_data;
    slave_run = 1'b0;
  endtask
  // next bit is put out just after each generated rise
  task automatic send_master(input logic [7:0] frame [$]);
    int i;
    int b;
    wait (pin_clock_oe === 1'b1);
    for (i = 0; i < frame.size(); i++) begin
      for (b = 7; b >= 0; b--) begin
        serial_data = frame[i][b];
        @(posedge config_clock_in);
        #2;
      end
    end
    serial_data = ~serial_data;
  endtask
endmodule // cfg_bit_source

// ==== cfg_link_shifter.sv ====
`timescale 1ns/100ps
// slave-mode capture, clocked by the partner's config_clock
module cfg_link_shifter (
  input wire logic link_clk,
  input wire logic serial_data,
  cfg_word_if.link lnk
);
  logic en_meta_reg;
  logic en_sync_reg;
  logic [3:0] bit_cnt_reg;
  logic [cfg_loader_pkg::WORD_W-1:0] shift_reg;
  logic [cfg_loader_pkg::WORD_W-1:0] word_reg;
  logic toggle_reg;

  always_ff @(posedge link_clk) begin
    en_meta_reg <= lnk.enable;
    en_sync_reg <= en_meta_reg;
  end

  // counts every edge while enabled, so the clock must stand still outside the frame
  always_ff @(posedge link_clk) begin
    if (!en_sync_reg) begin
      bit_cnt_reg <= 4'h0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge link_clk) begin
    shift_reg <= {shift_reg[cfg_loader_pkg::WORD_W-2:0], serial_data};
  end

  // word held stable for a full word time after the toggle flips
  always_ff @(posedge link_clk) begin
    if (!en_sync_reg) begin
      toggle_reg <= 1'b0;
      word_reg <= '0;
    end else if (bit_cnt_reg == cfg_loader_pkg::WORD_BIT_LAST) begin
      word_reg <= {shift_reg[cfg_loader_pkg::WORD_W-2:0], serial_data};
      toggle_reg <= ~toggle_reg;
    end
  end

  assign lnk.toggle = toggle_reg;
  assign lnk.word = word_reg;

  property p_link_bit_step;
    @(posedge link_clk) disable iff (!en_sync_reg)
    en_sync_reg |=> (bit_cnt_reg == $past(bit_cnt_reg) + 4'h1);
  endproperty
  a_link_bit_step: assert property (p_link_bit_step) else $error("slave bit count skipped");

  property p_link_word_toggle;
    @(posedge link_clk) disable iff (!en_sync_reg)
    (bit_cnt_reg == cfg_loader_pkg::WORD_BIT_LAST && en_meta_reg) |=>
      (toggle_reg != $past(toggle_reg)) && (word_reg[0] == $past(serial_data));
  endproperty
  a_link_word_toggle: assert property (p_link_word_toggle) else $error("slave word not delivered");
endmodule // cfg_link_shifter

// ==== cfg_loader_pkg.sv ====
// Overview of operation
// - One configuration bit enters per configuration clock cycle while loading, except the two slave lead edges; the master tail clocks after done carry none.
// - Master mode drives config_clock out; slave mode takes it as an input.
// - Bits arrive most significant first; first byte 0xAA starts one, zero, one.
// - Master clock is driven from init release until shortly after done rises.
// - Slave mode needs config_clock held still outside the frame; words count from the third edge after enable.
// - Done is open drain: pulled low, released to read high.
// - Init is open drain both ways: driven low, level sensed, pulled up outside.
// - Master mode puts out each byte after its eighth bit; slave mode puts out bytes in pairs per 16-bit word.
package cfg_loader_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int REF_CLK_PERIOD_NS = 40;
  localparam int INIT_CLEAR_NS = 400;
  localparam int INIT_CLEAR_CYCLES = (INIT_CLEAR_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int MASTER_CLK_PERIOD_NS = 160;
  localparam int MASTER_DIV_CYCLES = MASTER_CLK_PERIOD_NS / REF_CLK_PERIOD_NS;
  localparam int MASTER_HALF_CYCLES = MASTER_DIV_CYCLES / 2;
  localparam int DONE_TAIL_CLOCKS = 8;
  localparam logic [3:0] INIT_CLEAR_LAST = 4'(INIT_CLEAR_CYCLES - 1);
  localparam logic [3:0] DONE_TAIL_LAST = 4'(DONE_TAIL_CLOCKS - 1);
  localparam logic [1:0] MASTER_PHASE_RISE = 2'(MASTER_DIV_CYCLES - 1);
  localparam logic [1:0] MASTER_PHASE_FALL = 2'(MASTER_HALF_CYCLES - 1);
  localparam logic [3:0] WORD_BIT_LAST = 4'(WORD_W - 1);
  localparam logic [2:0] BYTE_BIT_LAST = 3'(BYTE_W - 1);
  localparam int SYNC_W = 4;
  localparam int SYNC_DIN = 0;
  localparam int SYNC_INIT = 1;
  localparam int SYNC_DONE = 2;
  localparam int SYNC_MODE = 3;
  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_WAIT_INIT,
    ST_LOAD,
    ST_TAIL,
    ST_FINISHED
  } loader_state_type;
endpackage

// ==== cfg_master_clock_gen.sv ====
`timescale 1ns/100ps
// divides ref_clk down to the master configuration clock
module cfg_master_clock_gen (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic run,
  output logic clk_out,
  output logic clk_oe,
  output logic clk_rise
);
  logic [1:0] phase_reg;
  logic clk_out_reg;
  logic clk_oe_reg;
  logic clk_rise_reg;

  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      phase_reg <= 2'h0;
    end else if (phase_reg == cfg_loader_pkg::MASTER_PHASE_RISE) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || !run) begin
      clk_out_reg <= 1'b0;
      clk_rise_reg <= 1'b0;
    end else begin
      clk_rise_reg <= (phase_reg == cfg_loader_pkg::MASTER_PHASE_RISE);
      if (phase_reg == cfg_loader_pkg::MASTER_PHASE_RISE) begin
        clk_out_reg <= 1'b1;
      end else if (phase_reg == cfg_loader_pkg::MASTER_PHASE_FALL) begin
        clk_out_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      clk_oe_reg <= 1'b0;
    end else begin
      clk_oe_reg <= run;
    end
  end

  assign clk_out = clk_out_reg;
  assign clk_oe = clk_oe_reg;
  assign clk_rise = clk_rise_reg;

  property p_rise_period;
    @(posedge ref_clk) disable iff (reset)
    (run && clk_rise_reg) |-> ##4 (clk_rise_reg || !run || $past(!run, 3));
  endproperty
  a_rise_period: assert property (p_rise_period) else $error("master clock period wrong");
endmodule // cfg_master_clock_gen

// ==== cfg_word_if.sv ====
`timescale 1ns/100ps
interface cfg_word_if;
  logic enable;
  logic toggle;
  logic [cfg_loader_pkg::WORD_W-1:0] word;
  modport link (input enable, output toggle, output word);
  modport core (output enable, input toggle, input word);
endinterface

// ==== serial_config_bit_loader.sv ====
`timescale 1ns/100ps
module serial_config_bit_loader (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic config_clock_in,
  input wire logic mode_master,
  input wire logic serial_data,
  input wire logic init_in,
  input wire logic done_in,
  input wire logic load_finish,
  output logic [cfg_loader_pkg::BYTE_W-1:0] cfg_byte,
  output logic cfg_byte_valid,
  output logic config_clock_out,
  output logic config_clock_oe,
  output logic init_out,
  output logic init_oe,
  output logic done_out,
  output logic done_oe
);
  cfg_word_if word_link ();

  cfg_loader_pkg::loader_state_type state_reg;
  cfg_loader_pkg::loader_state_type state_next;

  logic [cfg_loader_pkg::SYNC_W-1:0] pin_meta_reg;
  logic [cfg_loader_pkg::SYNC_W-1:0] pin_sync_reg;
  logic din_sync;
  logic init_sync;
  logic done_sync;
  logic mode_reg;
  logic [3:0] clear_cnt_reg;
  logic [3:0] tail_cnt_reg;
  logic run_reg;
  logic slave_en_reg;
  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_prev_reg;
  logic word_edge;
  logic clk_rise;
  logic take_bit;
  logic [cfg_loader_pkg::BYTE_W-1:0] mshift_reg;
  logic [2:0] mbit_cnt_reg;
  logic first_bit_reg;
  logic [cfg_loader_pkg::BYTE_W-1:0] lo_byte_reg;
  logic lo_pending_reg;
  logic [cfg_loader_pkg::BYTE_W-1:0] cfg_byte_reg;
  logic cfg_byte_valid_reg;
  logic init_oe_reg;
  logic done_oe_reg;
  logic init_out_reg;
  logic done_out_reg;

  cfg_link_shifter i_cfg_link_shifter (
    .link_clk(config_clock_in),
    .serial_data(serial_data),
    .lnk(word_link.link)
  );

  cfg_master_clock_gen i_cfg_master_clock_gen (
    .ref_clk(ref_clk),
    .reset(reset),
    .run(run_reg),
    .clk_out(config_clock_out),
    .clk_oe(config_clock_oe),
    .clk_rise(clk_rise)
  );

  // pins from outside the ref_clk domain
  always_ff @(posedge ref_clk) begin
    pin_meta_reg <= {mode_master, done_in, init_in, serial_data};
    pin_sync_reg <= pin_meta_reg;
  end

  assign din_sync = pin_sync_reg[cfg_loader_pkg::SYNC_DIN];
  assign init_sync = pin_sync_reg[cfg_loader_pkg::SYNC_INIT];
  assign done_sync = pin_sync_reg[cfg_loader_pkg::SYNC_DONE];

  // word-ready toggle from the slave clock domain
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tog_meta_reg <= 1'b0;
      tog_sync_reg <= 1'b0;
      tog_prev_reg <= 1'b0;
    end else begin
      tog_meta_reg <= word_link.toggle;
      tog_sync_reg <= tog_meta_reg;
      tog_prev_reg <= tog_sync_reg;
    end
  end

  assign word_edge = (tog_sync_reg ^ tog_prev_reg) && slave_en_reg;
  assign take_bit = mode_reg && (state_reg == cfg_loader_pkg::ST_LOAD) && clk_rise;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cfg_loader_pkg::ST_CLEAR: begin
        if (clear_cnt_reg == cfg_loader_pkg::INIT_CLEAR_LAST) begin
          state_next = cfg_loader_pkg::ST_WAIT_INIT;
        end
      end
      cfg_loader_pkg::ST_WAIT_INIT: begin
        if (init_sync) begin
          state_next = cfg_loader_pkg::ST_LOAD;
        end
      end
      cfg_loader_pkg::ST_LOAD: begin
        if (load_finish) begin
          state_next = cfg_loader_pkg::ST_TAIL;
        end
      end
      cfg_loader_pkg::ST_TAIL: begin
        if (done_sync && (!mode_reg ||
            (clk_rise && tail_cnt_reg == cfg_loader_pkg::DONE_TAIL_LAST))) begin
          state_next = cfg_loader_pkg::ST_FINISHED;
        end
      end
      cfg_loader_pkg::ST_FINISHED: begin
        state_next = cfg_loader_pkg::ST_FINISHED;
      end
      default: begin
        state_next = cfg_loader_pkg::ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= cfg_loader_pkg::ST_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  // strap is caught while init is still held low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mode_reg <= 1'b0;
      clear_cnt_reg <= 4'h0;
    end else if (state_reg == cfg_loader_pkg::ST_CLEAR) begin
      mode_reg <= pin_sync_reg[cfg_loader_pkg::SYNC_MODE];
      clear_cnt_reg <= clear_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tail_cnt_reg <= 4'h0;
    end else if (state_reg == cfg_loader_pkg::ST_TAIL && done_sync && clk_rise) begin
      tail_cnt_reg <= tail_cnt_reg + 4'h1;
    end
  end

  // master clock only from init release until the tail after done
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      run_reg <= 1'b0;
      slave_en_reg <= 1'b0;
    end else begin
      run_reg <= mode_reg && (state_next == cfg_loader_pkg::ST_LOAD ||
                              state_next == cfg_loader_pkg::ST_TAIL);
      slave_en_reg <= !mode_reg && (state_next == cfg_loader_pkg::ST_LOAD);
    end
  end

  assign word_link.enable = slave_en_reg;

  // open-drain pins: the output level is always low, only the enable moves
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      init_oe_reg <= 1'b1;
      done_oe_reg <= 1'b1;
      init_out_reg <= 1'b0;
      done_out_reg <= 1'b0;
    end else begin
      init_oe_reg <= (state_next == cfg_loader_pkg::ST_CLEAR);
      done_oe_reg <= (state_next != cfg_loader_pkg::ST_TAIL &&
                      state_next != cfg_loader_pkg::ST_FINISHED);
      init_out_reg <= 1'b0;
      done_out_reg <= 1'b0;
    end
  end

  // master mode bits come one per generated rising edge
  always_ff @(posedge ref_clk) begin
    if (reset || state_reg != cfg_loader_pkg::ST_LOAD) begin
      mbit_cnt_reg <= 3'h0;
      mshift_reg <= '0;
      first_bit_reg <= 1'b0;
    end else if (take_bit) begin
      mbit_cnt_reg <= mbit_cnt_reg + 3'h1;
      mshift_reg <= {mshift_reg[cfg_loader_pkg::BYTE_W-2:0], din_sync};
      if (mbit_cnt_reg == 3'h0) begin
        first_bit_reg <= din_sync;
      end
    end
  end

  // byte stream out; a slave word splits high byte first
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_byte_reg <= '0;
      cfg_byte_valid_reg <= 1'b0;
      lo_byte_reg <= '0;
      lo_pending_reg <= 1'b0;
    end else begin
      cfg_byte_valid_reg <= 1'b0;
      if (word_edge) begin
        cfg_byte_reg <= word_link.word[cfg_loader_pkg::WORD_W-1:cfg_loader_pkg::BYTE_W];
        lo_byte_reg <= word_link.word[cfg_loader_pkg::BYTE_W-1:0];
        cfg_byte_valid_reg <= 1'b1;
        lo_pending_reg <= 1'b1;
      end else if (lo_pending_reg) begin
        cfg_byte_reg <= lo_byte_reg;
        cfg_byte_valid_reg <= 1'b1;
        lo_pending_reg <= 1'b0;
      end else if (take_bit && mbit_cnt_reg == cfg_loader_pkg::BYTE_BIT_LAST) begin
        cfg_byte_reg <= {mshift_reg[cfg_loader_pkg::BYTE_W-2:0], din_sync};
        cfg_byte_valid_reg <= 1'b1;
      end
    end
  end

  assign cfg_byte = cfg_byte_reg;
  assign cfg_byte_valid = cfg_byte_valid_reg;
  assign init_out = init_out_reg;
  assign init_oe = init_oe_reg;
  assign done_out = done_out_reg;
  assign done_oe = done_oe_reg;

  property p_clock_dir;
    @(posedge ref_clk) disable iff (reset)
    config_clock_oe |-> mode_reg && !slave_en_reg;
  endproperty
  a_clock_dir: assert property (p_clock_dir) else $error("config clock driven in slave mode");

  property p_clock_window;
    @(posedge ref_clk) disable iff (reset)
    config_clock_oe |-> $past(state_reg, 2) inside {cfg_loader_pkg::ST_LOAD, cfg_loader_pkg::ST_TAIL,
                                                     cfg_loader_pkg::ST_WAIT_INIT};
  endproperty
  a_clock_window: assert property (p_clock_window) else $error("config clock outside window");

  property p_clock_tail;
    @(posedge ref_clk) disable iff (reset)
    (state_reg == cfg_loader_pkg::ST_TAIL && done_sync && mode_reg) |-> ##[1:40] !config_clock_oe;
  endproperty
  a_clock_tail: assert property (p_clock_tail) else $error("config clock not released after done");

  property p_done_open_drain;
    @(posedge ref_clk) disable iff (reset)
    (state_reg == cfg_loader_pkg::ST_LOAD) |=> !done_out && (done_oe || state_reg == cfg_loader_pkg::ST_TAIL);
  endproperty
  a_done_open_drain: assert property (p_done_open_drain) else $error("done not pulled low");

  property p_init_sensed;
    @(posedge ref_clk) disable iff (reset)
    $rose(state_reg == cfg_loader_pkg::ST_LOAD) |-> $past(init_sync) && !init_oe && !init_out;
  endproperty
  a_init_sensed: assert property (p_init_sensed) else $error("load began with init low");

  property p_master_bit_step;
    @(posedge ref_clk) disable iff (reset)
    take_bit |=> (mbit_cnt_reg == $past(mbit_cnt_reg) + 3'h1) && (mshift_reg[0] == $past(din_sync));
  endproperty
  a_master_bit_step: assert property (p_master_bit_step) else $error("master bit not taken");

  property p_master_msb_first;
    @(posedge ref_clk) disable iff (reset)
    (take_bit && mbit_cnt_reg == cfg_loader_pkg::BYTE_BIT_LAST && !word_edge && !lo_pending_reg)
      |=> cfg_byte_valid && (cfg_byte[cfg_loader_pkg::BYTE_W-1] == first_bit_reg);
  endproperty
  a_master_msb_first: assert property (p_master_msb_first) else $error("master byte not msb first");

  property p_slave_pair;
    @(posedge ref_clk) disable iff (reset)
    (word_edge && !lo_pending_reg) |=> cfg_byte_valid &&
      (cfg_byte == $past(word_link.word[cfg_loader_pkg::WORD_W-1:cfg_loader_pkg::BYTE_W]))
      ##1 cfg_byte_valid && (cfg_byte == $past(word_link.word[cfg_loader_pkg::BYTE_W-1:0], 2));
  endproperty
  a_slave_pair: assert property (p_slave_pair) else $error("slave word bytes out of order");

  property p_no_bits_after_load;
    @(posedge ref_clk) disable iff (reset)
    (state_reg == cfg_loader_pkg::ST_FINISHED) |-> ##3 !slave_en_reg && !run_reg && !cfg_byte_valid;
  endproperty
  a_no_bits_after_load: assert property (p_no_bits_after_load) else $error("bits taken after done");
endmodule // serial_config_bit_loader

// ==== serial_config_bit_loader_bench.sv ====
`timescale 1ns/100ps
module serial_config_bit_loader_bench;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset = 1'b1;
  logic mode_master = 1'b0;
  logic load_finish = 1'b0;
  logic config_clock_in;
  logic serial_data;
  logic init_in;
  logic done_in;
  logic [cfg_loader_pkg::BYTE_W-1:0] cfg_byte;
  logic cfg_byte_valid, config_clock_out, config_clock_oe;
  logic init_out, init_oe, done_out, done_oe;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] got_q [$];
  logic [7:0] tx_q [$];
  always #20 ref_clk = ~ref_clk;
  initial begin
    #3.3;
    forever #6 link_clk = ~link_clk;
  end
  assign init_in = init_oe ? init_out : 1'b1;
  assign done_in = done_oe ? done_out : 1'b1;
  serial_config_bit_loader i_serial_config_bit_loader (.ref_clk(ref_clk), .reset(reset),
    .config_clock_in(config_clock_in), .mode_master(mode_master), .serial_data(serial_data),
    .init_in(init_in), .done_in(done_in), .load_finish(load_finish), .cfg_byte(cfg_byte),
    .cfg_byte_valid(cfg_byte_valid), .config_clock_out(config_clock_out),
    .config_clock_oe(config_clock_oe), .init_out(init_out), .init_oe(init_oe),
    .done_out(done_out), .done_oe(done_oe));
  cfg_bit_source i_cfg_bit_source (.link_clk(link_clk), .mode_master(mode_master),
    .pin_clock_out(config_clock_out), .pin_clock_oe(config_clock_oe),
    .config_clock_in(config_clock_in), .serial_data(serial_data));
  always @(negedge ref_clk) begin
    if (cfg_byte_valid === 1'b1) got_q.push_back(cfg_byte);
    if (!reset && mode_master === 1'b0 && config_clock_oe !== 1'b0) begin
      check_bit(config_clock_oe, 1'b0);
    end
  end
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic check_num(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic check_bytes(input logic [7:0] exp [$]);
    int i;
    check_num(got_q.size(), exp.size());
    for (i = 0; i < exp.size() && i < got_q.size(); i++) begin
      n_compared++;
      if (got_q[i] !== exp[i]) begin
        num_errors++;
        $display("BAD %0t byte %0d got %h expected %h", $time, i, got_q[i], exp[i]);
      end
    end
  endtask
  // reset, then measure how long init is held low
  task automatic do_reset(input logic master);
    int n;
    @(negedge ref_clk);
    reset = 1'b1;
    mode_master = master;
    got_q.delete();
    fork
      repeat (10) @(negedge ref_clk);
      i_cfg_bit_source.prime_link();
    join
    check_bit(init_oe, 1'b1);
    check_bit(done_oe, 1'b1);
    check_bit(config_clock_oe, 1'b0);
    reset = 1'b0;
    n = 0;
    while (init_oe === 1'b1 && n < 40) begin
      @(negedge ref_clk);
      if (config_clock_oe !== 1'b0) check_bit(config_clock_oe, 1'b0);
      n++;
    end
    check_bit(n >= cfg_loader_pkg::INIT_CLEAR_CYCLES, 1'b1);
    check_bit(n <= cfg_loader_pkg::INIT_CLEAR_CYCLES + 1, 1'b1);
  endtask
  task automatic finish_load();
    @(negedge ref_clk);
    load_finish = 1'b1;
    @(negedge ref_clk);
    load_finish = 1'b0;
    @(negedge ref_clk);
    check_bit(done_oe, 1'b0);
    check_bit(done_in, 1'b1);
  endtask
  task automatic test_slave();
    do_reset(1'b0);
    repeat (8) @(negedge ref_clk);
    tx_q = {8'hAA, 8'h5C, 8'h0F, 8'hF1, 8'hC3};
    i_cfg_bit_source.send_slave(tx_q);
    repeat (10) @(negedge ref_clk);
    check_bytes({8'hAA, 8'h5C, 8'h0F, 8'hF1});
    finish_load();
    tx_q = {8'hFF, 8'h00, 8'h81};
    i_cfg_bit_source.send_slave(tx_q);
    repeat (10) @(negedge ref_clk);
    check_num(got_q.size(), 4);
  endtask
  // master mode stays available and must handle data as slave mode does
  task automatic test_master();
    realtime t0;
    int n;
    int rises;
    logic prev;
    do_reset(1'b1);
    tx_q = {8'hAA, 8'h3C, 8'h96};
    fork
      i_cfg_bit_source.send_master(tx_q);
      begin
        @(posedge config_clock_out);
        t0 = $realtime;
        @(posedge config_clock_out);
        check_num(int'($realtime - t0), cfg_loader_pkg::MASTER_CLK_PERIOD_NS);
      end
    join
    n = 0;
    while (got_q.size() < 3 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check_bytes(tx_q);
    check_bit(config_clock_oe, 1'b1);
    finish_load();
    rises = 0;
    prev = config_clock_out;
    n = 0;
    while (config_clock_oe === 1'b1 && n < 60) begin
      @(negedge ref_clk);
      if (config_clock_out === 1'b1 && prev !== 1'b1) rises++;
      prev = config_clock_out;
      n++;
    end
    check_num(rises, cfg_loader_pkg::DONE_TAIL_CLOCKS);
    repeat (20) @(negedge ref_clk);
    check_bit(config_clock_oe, 1'b0);
    check_num(got_q.size(), 3);
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #400000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    test_slave();
    test_master();
    wrap_up();
  end
endmodule // serial_config_bit_loader_bench
